// ==== hdl/fifo_pkg.sv ====
// Behaviour
// - Write and read data buses are nine bits, one word per transfer.
// - Full reset zeroes both pointers and the output register.
// - Full reset latches timing mode, default offset and programming method.
// - Pointer-only reset zeroes pointers and output, keeps mode and offsets.
// - Reread on a read-clock edge zeroes the read pointer, not the write pointer.
// - During reread empty shows active, or output-ready shows inactive.
// - After full reset the mode pin becomes the serial offset input.
// - Enabled write edge stores the word, or an offset word in parallel mode.
// - Serial-enabled write edge shifts exactly one bit into the offsets.
// - Enabled read edge presents next word, or offset contents when selected.
// - Output drive enable only switches the bus, never touches contents.
// - Offset-access level at full reset picks default offset and method.
// - After full reset offset access steers reads and writes to offsets.
// - Standard timing shows full; fall-through shows space available.
// - Standard timing shows empty; fall-through shows output data valid.
// - Almost-full goes low when count exceeds capacity minus full offset.
// - Almost-empty goes low when count is below the empty offset.
// - Half-full shows whether count is above half capacity.
// - Fall-through: first word appears after three read-clock transitions.
// - Offset access low picks 127 parallel, high picks 1,023 serial.
// - Standard timing: first word waits for an explicit enabled read.
package fifo_pkg;

   // Data and pointer geometry, sized for the deepest option.
   localparam int WORD_W      = 9;
   localparam int DEPTH_DEF   = 65536;
   localparam int PTR_W       = 18;
   localparam int OFF_W       = 17;
   localparam int OFF_HI_W    = OFF_W - WORD_W;
   localparam int STAGE_DEPTH = 16;

   // Default flag offsets chosen at full reset.
   localparam logic [OFF_W-1:0] OFF_DEF_PAR = 17'h0007f;
   localparam logic [OFF_W-1:0] OFF_DEF_SER = 17'h003ff;

   // Read-clock transitions before the first word falls through.
   localparam logic [1:0] FALL_TRANS = 2'h3;

   // Index of the offset word slots for parallel access.
   localparam logic [1:0] IDX_EMPTY_LO = 2'h0;
   localparam logic [1:0] IDX_EMPTY_HI = 2'h1;
   localparam logic [1:0] IDX_FULL_LO  = 2'h2;
   localparam logic [1:0] IDX_FULL_HI  = 2'h3;

   // Every pin input of the device, after synchronisation.
   typedef struct packed {
      logic              wclk;
      logic              rclk;
      logic              wen_n;
      logic              ren_n;
      logic              full_rst_n;
      logic              ptr_rst_n;
      logic              reread_n;
      logic              fwsi;
      logic              shift_n;
      logic              acc_n;
      logic              oe_n;
      logic [WORD_W-1:0] wdata;
   } pins_t;

   localparam int PIN_W = $bits(pins_t);

   // Registered status outputs.
   typedef struct packed {
      logic ffir;
      logic efor;
      logic afull_n;
      logic aempty_n;
      logic half_n;
      logic oe_n;
      logic stage_rdy;
   } flags_t;

   // Matches what the flag logic computes for an all-zero state, except oe_n, which is 1 here, so the
   // flag checks hold from the first edge after reset.
   localparam flags_t FLG_RST = 7'b1011111;

   // Whole state of the core.
   typedef struct packed {
      logic              wclk_q;
      logic              rclk_q;
      logic [PTR_W-1:0]  wr_ptr;
      logic [PTR_W-1:0]  rd_ptr;
      logic              ft_mode;
      logic              serial_mode;
      logic [OFF_W-1:0]  empty_off;
      logic [OFF_W-1:0]  full_off;
      logic [1:0]        pwr_idx;
      logic [1:0]        prd_idx;
      logic [WORD_W-1:0] out_reg;
      logic              out_valid;
      logic [1:0]        fall_cnt;
      logic              reread_busy;
      flags_t            flg;
   } core_state_t;

endpackage

// ==== hdl/sync2.sv ====
`timescale 1ns/1ps
// Two-stage synchroniser; only the second stage is visible.
module sync2
   import fifo_pkg::*;
#(
   parameter int W = 1
) (
   input  wire logic         core_clk,
   input  wire logic         nrst,
   input  wire logic         clk_en,
   input  wire logic [W-1:0] din,
   output logic      [W-1:0] dout
);

   typedef struct packed {
      logic [W-1:0] s1;
      logic [W-1:0] s2;
   } sync_t;

   sync_t st_ff;
   sync_t nxt_st;

   // Shift the pin level through both stages.
   always_comb begin
      nxt_st    = st_ff;
      nxt_st.s1 = din;
      nxt_st.s2 = st_ff.s1;
   end

   // Register the stages.
   always_ff @(posedge core_clk) begin
      if (!nrst) begin
         st_ff <= '0;
      end else if (clk_en) begin
         st_ff <= nxt_st;
      end
   end

   assign dout = st_ff.s2;

endmodule // sync2

// ==== hdl/stage_fifo.sv ====
`timescale 1ns/1ps
// Small staging FIFO with valid/ready on both sides.
module stage_fifo
   import fifo_pkg::*;
#(
   parameter int WIDTH = WORD_W,
   parameter int DEPTH = STAGE_DEPTH
) (
   input  wire logic             core_clk,
   input  wire logic             nrst,
   input  wire logic             clk_en,
   input  wire logic             flush,
   input  wire logic             in_valid,
   output logic                  in_ready,
   input  wire logic [WIDTH-1:0] in_data,
   output logic                  out_valid,
   input  wire logic             out_ready,
   output logic      [WIDTH-1:0] out_data
);

   localparam int AW = $clog2(DEPTH);

   typedef struct packed {
      logic [AW:0] wp;
      logic [AW:0] rp;
   } stage_t;

   stage_t           st_ff;
   stage_t           nxt_st;
   logic [WIDTH-1:0] mem [DEPTH];
   logic             push;
   logic             pop;

   // Full when pointers differ only in the wrap bit.
   assign in_ready  = !((st_ff.wp[AW] != st_ff.rp[AW]) &&
                        (st_ff.wp[AW-1:0] == st_ff.rp[AW-1:0]));
   assign out_valid = (st_ff.wp != st_ff.rp);
   assign out_data  = mem[st_ff.rp[AW-1:0]];
   assign push      = in_valid && in_ready && !flush;
   assign pop       = out_valid && out_ready && !flush;

   // Pointer update; a flush empties the buffer outright.
   always_comb begin
      nxt_st = st_ff;
      if (flush) begin
         nxt_st = '0;
      end else begin
         if (push) begin
            nxt_st.wp = st_ff.wp + {{AW{1'b0}}, 1'b1};
         end
         if (pop) begin
            nxt_st.rp = st_ff.rp + {{AW{1'b0}}, 1'b1};
         end
      end
   end

   // Register the pointers.
   always_ff @(posedge core_clk) begin
      if (!nrst) begin
         st_ff <= '0;
      end else if (clk_en) begin
         st_ff <= nxt_st;
      end
   end

   // Storage has no reset; only pointers define what is valid.
   always_ff @(posedge core_clk) begin
      if (clk_en && push) begin
         mem[st_ff.wp[AW-1:0]] <= in_data;
      end
   end

endmodule // stage_fifo

// ==== hdl/dc_fifo_core.sv ====
`timescale 1ns/1ps
// Deep nine-bit FIFO whose write and read clocks are sampled pins.
module dc_fifo_core
   import fifo_pkg::*;
#(
   parameter int DEPTH = DEPTH_DEF
) (
   input  wire logic              core_clk,
   input  wire logic              nrst,
   input  wire logic              clk_en,
   input  wire logic              write_clk,
   input  wire logic              read_clk,
   input  wire logic              write_en_n,
   input  wire logic              read_en_n,
   input  wire logic [WORD_W-1:0] write_data_in,
   input  wire logic              full_reset_n,
   input  wire logic              pointer_only_reset_n,
   input  wire logic              reread_request_n,
   input  wire logic              fall_through_sel_serial_in,
   input  wire logic              serial_shift_gate_n,
   input  wire logic              offset_access_n,
   input  wire logic              out_drive_en_n,
   output logic      [WORD_W-1:0] read_data_out,
   output logic                   read_data_oe_n,
   output logic                   full_or_input_ready,
   output logic                   empty_or_output_ready,
   output logic                   almost_full_n,
   output logic                   almost_empty_n,
   output logic                   half_full_n,
   output logic                   stage_ready
);

   localparam int               AW      = $clog2(DEPTH);
   localparam logic [PTR_W-1:0] DEPTH_P = PTR_W'(DEPTH);
   localparam logic [PTR_W-1:0] HALF_P  = PTR_W'(DEPTH / 2);
   localparam logic [PTR_W-1:0] PTR_ONE = 18'h00001;

   core_state_t         st_ff;
   core_state_t         nxt_st;
   pins_t               pin_raw;
   pins_t               p;
   logic [WORD_W-1:0]   mem [DEPTH];
   logic [WORD_W-1:0]   mem_rd;
   logic                wr_edge;
   logic                rd_edge;
   logic                rd_tr;
   logic [PTR_W-1:0]    cnt;
   logic [PTR_W-1:0]    ncnt;
   logic                mem_full;
   logic                flush;
   logic                stg_in_valid;
   logic                stg_in_ready;
   logic                stg_out_valid;
   logic                stg_out_ready;
   logic [WORD_W-1:0]   stg_out_data;
   logic [2*OFF_W-1:0]  shift_reg;

   // Gather every pin so one synchroniser bank handles them.
   assign pin_raw = '{wclk: write_clk, rclk: read_clk, wen_n: write_en_n,
                      ren_n: read_en_n, full_rst_n: full_reset_n,
                      ptr_rst_n: pointer_only_reset_n,
                      reread_n: reread_request_n,
                      fwsi: fall_through_sel_serial_in,
                      shift_n: serial_shift_gate_n, acc_n: offset_access_n,
                      oe_n: out_drive_en_n, wdata: write_data_in};

   sync2 #(
      .W        (PIN_W)
   ) u_sync (
      .core_clk (core_clk),
      .nrst     (nrst),
      .clk_en   (clk_en),
      .din      (pin_raw),
      .dout     (p)
   );

   // one sampled domain
   // Both link clocks are sampled here, so pointers never cross domains.
   assign wr_edge  = p.wclk && !st_ff.wclk_q;
   assign rd_edge  = p.rclk && !st_ff.rclk_q;
   assign rd_tr    = p.rclk != st_ff.rclk_q;
   assign cnt      = st_ff.wr_ptr - st_ff.rd_ptr;
   assign mem_full = (cnt == DEPTH_P);
   assign mem_rd   = mem[st_ff.rd_ptr[AW-1:0]];
   assign flush    = !p.full_rst_n || !p.ptr_rst_n;

   // buffer write path
   // Writes land in the staging FIFO first; a word offered while it is
   // full is dropped, which the stage_ready output makes visible.
   assign stg_in_valid  = wr_edge && !p.wen_n && p.acc_n && !mem_full;
   assign stg_out_ready = !mem_full && !flush;

   stage_fifo #(
      .WIDTH     (WORD_W),
      .DEPTH     (STAGE_DEPTH)
   ) u_stage (
      .core_clk  (core_clk),
      .nrst      (nrst),
      .clk_en    (clk_en),
      .flush     (flush),
      .in_valid  (stg_in_valid),
      .in_ready  (stg_in_ready),
      .in_data   (p.wdata),
      .out_valid (stg_out_valid),
      .out_ready (stg_out_ready),
      .out_data  (stg_out_data)
   );

   // Next-state logic for resets, offsets, reads and flags.
   always_comb begin
      nxt_st        = st_ff;
      shift_reg     = {st_ff.full_off, st_ff.empty_off};
      nxt_st.wclk_q = p.wclk;
      nxt_st.rclk_q = p.rclk;
      if (!p.full_rst_n) begin
         nxt_st.wr_ptr      = '0;
         nxt_st.rd_ptr      = '0;
         nxt_st.out_reg     = '0;
         nxt_st.out_valid   = 1'b0;
         nxt_st.fall_cnt    = '0;
         nxt_st.reread_busy = 1'b0;
         nxt_st.pwr_idx     = '0;
         nxt_st.prd_idx     = '0;
         nxt_st.ft_mode     = p.fwsi;
         nxt_st.serial_mode = p.acc_n;
         nxt_st.empty_off   = p.acc_n ? OFF_DEF_SER : OFF_DEF_PAR;
         nxt_st.full_off    = p.acc_n ? OFF_DEF_SER : OFF_DEF_PAR;
      end else if (!p.ptr_rst_n) begin
         nxt_st.wr_ptr      = '0;
         nxt_st.rd_ptr      = '0;
         nxt_st.out_reg     = '0;
         nxt_st.out_valid   = 1'b0;
         nxt_st.fall_cnt    = '0;
         nxt_st.reread_busy = 1'b0;
         nxt_st.pwr_idx     = '0;
         nxt_st.prd_idx     = '0;
      end else begin
         // Drain one staged word per cycle into the deep memory.
         if (stg_out_valid && stg_out_ready) begin
            nxt_st.wr_ptr = st_ff.wr_ptr + PTR_ONE;
         end
         if (wr_edge && !p.acc_n) begin
            if (!p.wen_n && !st_ff.serial_mode) begin
               case (st_ff.pwr_idx)
                  IDX_EMPTY_LO: nxt_st.empty_off[WORD_W-1:0] = p.wdata;
                  IDX_EMPTY_HI: nxt_st.empty_off[OFF_W-1:WORD_W] =
                                   p.wdata[OFF_HI_W-1:0];
                  IDX_FULL_LO:  nxt_st.full_off[WORD_W-1:0] = p.wdata;
                  default:      nxt_st.full_off[OFF_W-1:WORD_W] =
                                   p.wdata[OFF_HI_W-1:0];
               endcase
               nxt_st.pwr_idx = st_ff.pwr_idx + 2'h1;
            end else if (!p.shift_n && st_ff.serial_mode) begin
               shift_reg        = {p.fwsi, shift_reg[2*OFF_W-1:1]};
               nxt_st.empty_off = shift_reg[OFF_W-1:0];
               nxt_st.full_off  = shift_reg[2*OFF_W-1:OFF_W];
            end
         end
         if (rd_edge && !p.reread_n) begin
            nxt_st.rd_ptr      = '0;
            nxt_st.reread_busy = 1'b1;
            nxt_st.out_valid   = 1'b0;
            nxt_st.fall_cnt    = '0;
         end else if (rd_edge && !p.ren_n && !p.acc_n) begin
            case (st_ff.prd_idx)
               IDX_EMPTY_LO: nxt_st.out_reg = st_ff.empty_off[WORD_W-1:0];
               IDX_EMPTY_HI: nxt_st.out_reg =
                                {1'b0, st_ff.empty_off[OFF_W-1:WORD_W]};
               IDX_FULL_LO:  nxt_st.out_reg = st_ff.full_off[WORD_W-1:0];
               default:      nxt_st.out_reg =
                                {1'b0, st_ff.full_off[OFF_W-1:WORD_W]};
            endcase
            nxt_st.prd_idx = st_ff.prd_idx + 2'h1;
         end else begin
            if (rd_edge) begin
               nxt_st.reread_busy = 1'b0;
            end
            if (!st_ff.ft_mode) begin
               if (rd_edge && !p.ren_n && cnt != '0) begin
                  nxt_st.out_reg = mem_rd;
                  nxt_st.rd_ptr  = st_ff.rd_ptr + PTR_ONE;
               end
            end else if (st_ff.out_valid) begin
               // Fall-through: a read replaces the shown word or drops it.
               if (rd_edge && !p.ren_n) begin
                  if (cnt != '0) begin
                     nxt_st.out_reg = mem_rd;
                     nxt_st.rd_ptr  = st_ff.rd_ptr + PTR_ONE;
                  end else begin
                     nxt_st.out_valid = 1'b0;
                  end
               end
            end else if (cnt != '0 && !st_ff.reread_busy && rd_tr) begin
               if (st_ff.fall_cnt == FALL_TRANS - 2'h1) begin
                  nxt_st.out_reg   = mem_rd;
                  nxt_st.rd_ptr    = st_ff.rd_ptr + PTR_ONE;
                  nxt_st.out_valid = 1'b1;
                  nxt_st.fall_cnt  = '0;
               end else begin
                  nxt_st.fall_cnt = st_ff.fall_cnt + 2'h1;
               end
            end
         end
      end
      // Flags follow the next state so they never lag the pointers.
      ncnt = nxt_st.wr_ptr - nxt_st.rd_ptr;
      nxt_st.flg.ffir = nxt_st.ft_mode ? (ncnt == DEPTH_P)
                                       : (ncnt != DEPTH_P);
      if (nxt_st.ft_mode) begin
         nxt_st.flg.efor = nxt_st.reread_busy || !nxt_st.out_valid;
      end else begin
         nxt_st.flg.efor = !nxt_st.reread_busy && (ncnt != '0);
      end
      nxt_st.flg.afull_n  = !(ncnt > DEPTH_P - {1'b0, nxt_st.full_off});
      nxt_st.flg.aempty_n = !(ncnt < {1'b0, nxt_st.empty_off});
      nxt_st.flg.half_n   = !(ncnt > HALF_P);
      nxt_st.flg.oe_n      = p.oe_n;
      nxt_st.flg.stage_rdy = stg_in_ready;
   end

   // Register the state; flags come out of reset showing empty.
   always_ff @(posedge core_clk) begin
      if (!nrst) begin
         st_ff     <= '0;
         st_ff.flg <= FLG_RST;
      end else if (clk_en) begin
         st_ff <= nxt_st;
      end
   end

   // nine-bit storage
   // Deep storage has no reset, so pointer resets leave old data behind.
   always_ff @(posedge core_clk) begin
      if (clk_en && stg_out_valid && stg_out_ready) begin
         mem[st_ff.wr_ptr[AW-1:0]] <= stg_out_data;
      end
   end

   assign read_data_out         = st_ff.out_reg;
   assign read_data_oe_n        = st_ff.flg.oe_n;
   assign full_or_input_ready   = st_ff.flg.ffir;
   assign empty_or_output_ready = st_ff.flg.efor;
   assign almost_full_n         = st_ff.flg.afull_n;
   assign almost_empty_n        = st_ff.flg.aempty_n;
   assign half_full_n           = st_ff.flg.half_n;
   assign stage_ready           = st_ff.flg.stage_rdy;

   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!nrst);

   // Full reset clears output and read pointer.
   full_clears_a: assert property (
      (!p.full_rst_n && clk_en) |=>
         (read_data_out == '0 && st_ff.rd_ptr == '0))
      else $error("full reset did not clear output or pointer");

   // Configuration follows the pins held during full reset.
   full_latch_a: assert property (
      (!p.full_rst_n && clk_en) |=> (st_ff.ft_mode == $past(p.fwsi) &&
                                    st_ff.serial_mode == $past(p.acc_n)))
      else $error("full reset did not latch configuration");

   // Pointer-only reset keeps configuration.
   ptr_keeps_a: assert property (
      (p.full_rst_n && !p.ptr_rst_n && clk_en) |=>
         ($stable(st_ff.ft_mode) && $stable(st_ff.empty_off) &&
          $stable(st_ff.full_off) && st_ff.wr_ptr == '0))
      else $error("pointer-only reset disturbed configuration");

   // Reread rewinds the read pointer and marks the busy phase.
   reread_rewind_a: assert property (
      (rd_edge && !p.reread_n && p.full_rst_n && p.ptr_rst_n && clk_en) |=>
         (st_ff.rd_ptr == '0 && st_ff.reread_busy))
      else $error("reread did not rewind read pointer");

   // Empty shows active, or output-ready inactive, while rereading.
   reread_flag_a: assert property (
      st_ff.reread_busy |-> (empty_or_output_ready == st_ff.ft_mode))
      else $error("reread flag level wrong");

   // Full flag polarity follows the timing mode.
   full_flag_a: assert property (
      full_or_input_ready == (st_ff.ft_mode ? mem_full : !mem_full))
      else $error("full or input-ready flag wrong");

   // Almost-full threshold against the full offset.
   almost_full_a: assert property (
      almost_full_n == !(cnt > DEPTH_P - {1'b0, st_ff.full_off}))
      else $error("almost-full flag wrong");

   // Almost-empty threshold against the empty offset.
   almost_empty_a: assert property (
      almost_empty_n == !(cnt < {1'b0, st_ff.empty_off}))
      else $error("almost-empty flag wrong");

   // Half-full threshold.
   half_full_a: assert property (
      half_full_n == !(cnt > HALF_P))
      else $error("half-full flag wrong");

   // Outside resets, standard timing never changes the output word without a read enable.
   std_no_fall_a: assert property (
      (!st_ff.ft_mode && p.full_rst_n && p.ptr_rst_n && p.ren_n &&
       p.reread_n && clk_en && st_ff.flg.stage_rdy) |=>
         $stable(read_data_out))
      else $error("standard timing word fell through");

endmodule // dc_fifo_core

// ==== tb/far_side.sv ====
`timescale 1ns/1ps
// Producer and consumer on the link ports; link clocks idle low.
module far_side
   import fifo_pkg::*;
(
   output logic              write_clk,
   output logic              write_en_n,
   output logic              serial_shift_gate_n,
   output logic              fts_in,
   output logic [WORD_W-1:0] write_data_in,
   output logic              read_clk,
   output logic              read_en_n,
   output logic              reread_request_n
);
   // Quiet levels from time zero.
   initial begin
      write_clk = 1'b0;
      read_clk = 1'b0;
      write_en_n = 1'b1;
      read_en_n = 1'b1;
      serial_shift_gate_n = 1'b1;
      reread_request_n = 1'b1;
      fts_in = 1'b0;
      write_data_in = 9'h000;
   end
   // nine-bit word or one serial bit per pulse.
   // A gap before the new request keeps release and request apart.
   task automatic wcyc(input logic wen_n, shift_n,
                       input logic [WORD_W-1:0] d);
      #20;
      write_en_n = wen_n;
      serial_shift_gate_n = shift_n;
      write_data_in = d;
      fts_in = d[0];
      #60 write_clk = 1'b1;
      #80 write_clk = 1'b0;
      // Released lines go inverse so stale data is never taken for new.
      write_en_n = 1'b1;
      serial_shift_gate_n = 1'b1;
      write_data_in = ~d;
      fts_in = ~d[0];
   endtask
   // One read clock pulse; enables held across the rising edge.
   task automatic rcyc(input logic ren_n, reread_n);
      #20;
      read_en_n = ren_n;
      reread_request_n = reread_n;
      #60 read_clk = 1'b1;
      #80 read_clk = 1'b0;
      read_en_n = 1'b1;
      reread_request_n = 1'b1;
   endtask
endmodule // far_side

// ==== tb/tb_top.sv ====
`timescale 1ns/1ps
`define CHK(got, exp) begin \
   checks++; \
   if ((got) !== (exp)) begin \
      error_cnt++; \
      $display("unexpected at %0t: got %h exp %h", $time, got, exp); \
   end \
end
module tb_top;
   import fifo_pkg::*;
   // Small depth keeps the fill and drain short.
   localparam int DEPTH = 64;
   localparam logic [33:0] SER_BITS = {17'h00006, 17'h00005};
   logic core_clk, nrst, clk_en, full_reset_n, pointer_only_reset_n;
   logic offset_access_n, out_drive_en_n, write_clk, read_clk;
   logic write_en_n, read_en_n, fall_through_sel_serial_in;
   logic serial_shift_gate_n, reread_request_n, read_data_oe_n;
   logic full_or_input_ready, empty_or_output_ready, almost_full_n;
   logic almost_empty_n, half_full_n, stage_ready;
   logic [WORD_W-1:0] write_data_in, read_data_out;
   int error_cnt = 0;
   int checks = 0;
   int i, cnt;
   initial begin
      core_clk = 1'b0;
      forever #10 core_clk = ~core_clk;
   end
   dc_fifo_core #(.DEPTH(DEPTH)) u_dut (
      .core_clk(core_clk), .nrst(nrst), .clk_en(clk_en),
      .write_clk(write_clk), .read_clk(read_clk),
      .write_en_n(write_en_n), .read_en_n(read_en_n),
      .write_data_in(write_data_in), .full_reset_n(full_reset_n),
      .pointer_only_reset_n(pointer_only_reset_n),
      .reread_request_n(reread_request_n),
      .fall_through_sel_serial_in(fall_through_sel_serial_in),
      .serial_shift_gate_n(serial_shift_gate_n),
      .offset_access_n(offset_access_n), .out_drive_en_n(out_drive_en_n),
      .read_data_out(read_data_out), .read_data_oe_n(read_data_oe_n),
      .full_or_input_ready(full_or_input_ready),
      .empty_or_output_ready(empty_or_output_ready),
      .almost_full_n(almost_full_n), .almost_empty_n(almost_empty_n),
      .half_full_n(half_full_n), .stage_ready(stage_ready));
   far_side u_far (
      .write_clk(write_clk), .write_en_n(write_en_n),
      .serial_shift_gate_n(serial_shift_gate_n),
      .fts_in(fall_through_sel_serial_in), .write_data_in(write_data_in),
      .read_clk(read_clk), .read_en_n(read_en_n),
      .reread_request_n(reread_request_n));
   task automatic wait_cyc(input int n);
      repeat (n) @(posedge core_clk);
      #1;
   endtask
   // Pin reset pulse; only the full one may latch mode and offsets.
   task automatic pin_rst(input logic full, ft, acc_n);
      full_reset_n = ~full;
      pointer_only_reset_n = full;
      offset_access_n = acc_n;
      u_far.fts_in = ft;
      wait_cyc(6);
      full_reset_n = 1'b1;
      pointer_only_reset_n = 1'b1;
      offset_access_n = 1'b1;
      wait_cyc(4);
   endtask
   // Walks the four offset words, writing them or comparing them.
   task automatic off_io(input logic wr, input logic [OFF_W-1:0] e, f);
      logic [OFF_W-1:0] tmp;
      offset_access_n = 1'b0;
      for (int k = 0; k < 4; k++) begin
         tmp = ((k < 2) ? e : f) >> ((k % 2) * 9);
         if (wr) begin
            u_far.wcyc(1'b0, 1'b1, tmp[8:0]);
         end else begin
            u_far.rcyc(1'b0, 1'b1);
            wait_cyc(2);
            `CHK(read_data_out, tmp[8:0])
         end
      end
      offset_access_n = 1'b1;
      wait_cyc(1);
   endtask
   task automatic complete_run;
      $display("mismatches %0d, comparisons %0d", error_cnt, checks);
      if (error_cnt == 0 && checks > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask
   // Cuts a hang short well beyond the expected run time.
   initial begin
      #300000;
      error_cnt++;
      complete_run;
   end
   initial begin
      nrst = 1'b0;
      clk_en = 1'b1;
      full_reset_n = 1'b1;
      pointer_only_reset_n = 1'b1;
      offset_access_n = 1'b1;
      out_drive_en_n = 1'b0;
      wait_cyc(10);
      nrst = 1'b1;
      wait_cyc(2);
      // Standard timing, parallel offsets with the small default.
      pin_rst(1'b1, 1'b0, 1'b0);
      `CHK({read_data_out, empty_or_output_ready}, 10'h000)
      `CHK(full_or_input_ready, 1'b1)
      off_io(1'b0, OFF_DEF_PAR, OFF_DEF_PAR);
      off_io(1'b1, 17'h00004, 17'h00004);
      off_io(1'b0, 17'h00004, 17'h00004);
      `CHK(empty_or_output_ready, 1'b0)
      // Fill one past capacity; the extra word must be dropped.
      for (i = 0; i <= DEPTH; i++) begin
         u_far.wcyc(1'b0, 1'b1, 9'h100 + i[8:0]);
         if (i == 2) begin
            wait_cyc(4);
            `CHK({read_data_out, empty_or_output_ready}, 10'h001)
         end
      end
      wait_cyc(6);
      `CHK({full_or_input_ready, almost_full_n, stage_ready}, 3'h1)
      // Drain, checking the almost-full, half-full, almost-empty and empty boundaries on the way down.
      for (i = 0; i < DEPTH; i++) begin
         u_far.rcyc(1'b0, 1'b1);
         wait_cyc(4);
         cnt = DEPTH - 1 - i;
         `CHK(read_data_out, 9'h100 + i[8:0])
         `CHK({almost_full_n, half_full_n}, {cnt <= 60, cnt <= 32})
         `CHK({almost_empty_n, empty_or_output_ready}, {cnt >= 4, cnt > 0})
      end
      u_far.rcyc(1'b0, 1'b1);
      wait_cyc(4);
      out_drive_en_n = 1'b1;
      wait_cyc(3);
      `CHK({read_data_oe_n, read_data_out}, {1'b1, 9'h13f})
      out_drive_en_n = 1'b0;
      // Reread: empty shown meanwhile, then location zero again.
      u_far.rcyc(1'b1, 1'b0);
      wait_cyc(4);
      `CHK(empty_or_output_ready, 1'b0)
      u_far.rcyc(1'b0, 1'b1);
      wait_cyc(4);
      `CHK({read_data_out, half_full_n}, {9'h100, 1'b0})
      // Pointer-only reset must not relatch mode or offsets.
      pin_rst(1'b0, 1'b1, 1'b1);
      `CHK({read_data_out, empty_or_output_ready}, 10'h000)
      off_io(1'b0, 17'h00004, 17'h00004);
      // Fall-through timing, serial offsets with the large default.
      pin_rst(1'b1, 1'b1, 1'b1);
      `CHK({empty_or_output_ready, full_or_input_ready}, 2'b10)
      off_io(1'b0, OFF_DEF_SER, OFF_DEF_SER);
      offset_access_n = 1'b0;
      for (i = 0; i < 34; i++) begin
         u_far.wcyc(1'b1, 1'b0, {8'h00, SER_BITS[i]});
      end
      offset_access_n = 1'b1;
      wait_cyc(1);
      off_io(1'b0, 17'h00005, 17'h00006);
      u_far.wcyc(1'b0, 1'b1, 9'h0a5);
      wait_cyc(6);
      `CHK(empty_or_output_ready, 1'b1)
      u_far.rcyc(1'b1, 1'b1);
      u_far.rcyc(1'b1, 1'b1);
      wait_cyc(4);
      `CHK({read_data_out, empty_or_output_ready}, 10'h14a)
      complete_run;
   end
endmodule // tb_top
